// ===== src/psc_pkg.sv
// Constants for the per-port statistics counter bank
package psc_pkg;
  // Register port offsets
  localparam logic [7:0] REG_TABLE_SELECT = 8'h79;
  localparam logic [7:0] REG_TABLE_OFFSET = 8'h7A;
  localparam logic [7:0] REG_RESULT_3     = 8'h80;
  localparam logic [7:0] REG_RESULT_2     = 8'h81;
  localparam logic [7:0] REG_RESULT_1     = 8'h82;
  localparam logic [7:0] REG_RESULT_0     = 8'h83;
  localparam logic [7:0] REG_RESET_VAL    = 8'h00;

  // Table select: upper six bits pick the table, low two bits are address bits 9:8
  localparam logic [5:0] TABLE_MIB        = 6'h07;
  localparam int         SEL_TABLE_LSB    = 2;

  // Indirect address layout
  localparam logic [9:0] PORT_AREA_END    = 10'h060;
  localparam logic [9:0] DROP_BASE        = 10'h100;
  localparam int         DROP_COUNT       = 6;
  localparam int         ADDR_PORT_LSB    = 5;
  localparam int         ADDR_IDX_W       = 5;

  // Counter indices inside one port block
  localparam logic [4:0] IDX_RX_1024_MAX  = 5'h13;
  localparam logic [4:0] IDX_TX_LO_OCT    = 5'h14;
  localparam logic [4:0] IDX_TX_HI_OCT    = 5'h15;
  localparam logic [4:0] IDX_TX_LATE_COLL = 5'h16;
  localparam logic [4:0] IDX_TX_PAUSE     = 5'h17;
  localparam logic [4:0] IDX_TX_BCAST     = 5'h18;
  localparam logic [4:0] IDX_TX_MCAST     = 5'h19;
  localparam logic [4:0] IDX_TX_UCAST     = 5'h1A;
  localparam logic [4:0] IDX_TX_POSTPONED = 5'h1B;
  localparam logic [4:0] IDX_TX_ALL_COLL  = 5'h1C;
  localparam logic [4:0] IDX_TX_ABANDONED = 5'h1D;
  localparam logic [4:0] IDX_TX_ONE_COLL  = 5'h1E;
  localparam logic [4:0] IDX_TX_MULTI     = 5'h1F;
  localparam int         SLOT_COUNT       = 13;

  // Result word fields
  localparam int         RES_OVF_BIT      = 31;
  localparam int         RES_VALID_BIT    = 30;

  // Frame length bins
  localparam logic [10:0] LEN_BIN_LOW     = 11'h400;
  localparam logic [10:0] LEN_MAX_STD     = 11'h5F2;
  localparam logic [10:0] LEN_MAX_LONG    = 11'h600;
endpackage

// ===== src/psc_stats_counters.sv
// Per-port statistics and dropped-frame counters read through an indirect window
//
// Behaviour
// [RULE1] Offsets 0x14/0x15 add good tx octets, pause included
// [RULE2] Offset 0x13 counts rx frames 1024 to maximum
// [RULE3] Offset 0x16 counts late collisions past 512 bits
// [RULE4] 0x17 pause, 0x18-0x1A good bcast/mcast/ucast sent
// [RULE5] Offset 0x1B counts frames postponed by busy medium
// [RULE6] Offset 0x1C counts collisions in half duplex only
// [RULE7] Offset 0x1D counts frames dropped on excessive collisions
// [RULE8] 0x1E/0x1F count sent after one/several collisions
// [RULE9] Dropped counters give 16 bits, upper bits zero
// [RULE10] Dropped counters at 0x100-0x105: tx then rx
// [RULE11] Host writes 0x1c to 0x79 first
// [RULE12] Writing offset to 0x7A triggers the read
// [RULE13] Result in 0x80-0x83 with overflow and valid
// [RULE14] Dropped result sits in 0x82 and 0x83
// [RULE15] Per-port counters clear when read
// [RULE16] Dropped counters keep value, carry no flags
// [RULE17] Host sweeps all counters at least every 30s
// [RULE18] Port blocks at bases 0x00, 0x20, 0x40
// [RULE19] Per-port counters wrap and latch overflow
`timescale 1ns/1ps
`default_nettype none

module psc_stats_counters #(
  parameter int PORTS  = 3,
  parameter int LEN_W  = 11,
  parameter int CNT_W  = 30,
  parameter int DROP_W = 16,
  parameter int COLL_W = 5
) (
  input  wire logic                           clk_i,
  input  wire logic                           reset_n_i,
  // Register port from the serial management interface
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  input  wire logic [7:0]                     reg_addr_i,
  input  wire logic [7:0]                     reg_wdata_i,
  output logic      [7:0]                     reg_rdata_o,
  // Configuration
  input  wire logic                           max_frame_long_i,
  input  wire logic [PORTS-1:0]               half_duplex_i,
  // Receive events
  input  wire logic [PORTS-1:0]               rx_frame_done_i,
  input  wire logic [PORTS-1:0][LEN_W-1:0]    rx_frame_len_i,
  // Transmit events
  input  wire logic [PORTS-1:0]               tx_frame_done_i,
  input  wire logic [PORTS-1:0][LEN_W-1:0]    tx_frame_len_i,
  input  wire logic [PORTS-1:0]               tx_good_i,
  input  wire logic [PORTS-1:0]               tx_hi_prio_i,
  input  wire logic [PORTS-1:0]               tx_pause_i,
  input  wire logic [PORTS-1:0]               tx_bcast_i,
  input  wire logic [PORTS-1:0]               tx_mcast_i,
  input  wire logic [PORTS-1:0]               tx_postponed_i,
  input  wire logic [PORTS-1:0][COLL_W-1:0]   tx_coll_cnt_i,
  input  wire logic [PORTS-1:0]               tx_abandoned_i,
  input  wire logic [PORTS-1:0]               tx_late_coll_i,
  input  wire logic [PORTS-1:0]               tx_coll_i,
  // Buffer shortage drops
  input  wire logic [PORTS-1:0]               tx_drop_i,
  input  wire logic [PORTS-1:0]               rx_drop_i
);

  localparam int SLOTS = psc_pkg::SLOT_COUNT;

  // Counter storage: only the implemented tail of each port block
  logic [CNT_W-1:0]  cnt_r    [PORTS][SLOTS];
  logic              ovf_r    [PORTS][SLOTS];
  logic [DROP_W-1:0] drop_r   [2*PORTS];
  logic [LEN_W-1:0]  inc      [PORTS][SLOTS];

  logic [7:0]        sel_r;
  logic [7:0]        ofs_r;
  logic [31:0]       result_r;
  logic [7:0]        reg_rdata_r;

  logic              trig;
  logic [9:0]        rd_addr;
  logic              rd_mib;
  logic              rd_port_area;
  logic [1:0]        rd_port;
  logic [4:0]        rd_idx;
  logic              rd_slot_hit;
  logic [3:0]        rd_slot;
  logic              rd_drop_hit;
  logic [2:0]        rd_drop;
  logic [LEN_W-1:0]  len_max;

  // Slot number of a counter index within a port block
  function automatic logic [3:0] slot_of(input logic [4:0] idx);
    logic [4:0] d;
    d = idx - psc_pkg::IDX_RX_1024_MAX;
    return d[3:0];
  endfunction

  // Add an increment, wrapping at the counter width and reporting the carry
  function automatic logic [CNT_W:0] add_wrap(input logic [CNT_W-1:0] base, input logic [LEN_W-1:0] amt);
    return {1'b0, base} + {{(CNT_W+1-LEN_W){1'b0}}, amt};
  endfunction

  // Decode of the triggered indirect address
  assign trig         = reg_wr_i && (reg_addr_i == psc_pkg::REG_TABLE_OFFSET); // see [RULE12]
  assign rd_addr      = {sel_r[1:0], reg_wdata_i};
  assign rd_mib       = (sel_r[7:psc_pkg::SEL_TABLE_LSB] == psc_pkg::TABLE_MIB); // see [RULE11]
  assign rd_port_area = (rd_addr < psc_pkg::PORT_AREA_END);
  assign rd_port      = rd_addr[psc_pkg::ADDR_PORT_LSB +: 2];                  // see [RULE18]
  assign rd_idx       = rd_addr[psc_pkg::ADDR_IDX_W-1:0];
  assign rd_slot      = slot_of(rd_idx);
  assign rd_slot_hit  = rd_mib && rd_port_area && (rd_idx >= psc_pkg::IDX_RX_1024_MAX);
  assign rd_drop_hit  = rd_mib && (rd_addr >= psc_pkg::DROP_BASE) &&
                        (rd_addr < psc_pkg::DROP_BASE + 10'(psc_pkg::DROP_COUNT)); // see [RULE10]
  assign rd_drop      = 3'(rd_addr - psc_pkg::DROP_BASE);

  // Frame length ceiling follows the configured maximum size
  assign len_max = max_frame_long_i ? psc_pkg::LEN_MAX_LONG : psc_pkg::LEN_MAX_STD;

  // Per-event increments for every counter; an octet counter adds a length, others add one
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      for (int k = 0; k < SLOTS; k++) begin
        inc[p][k] = '0;
      end
      if (rx_frame_done_i[p] && rx_frame_len_i[p] >= psc_pkg::LEN_BIN_LOW &&
          rx_frame_len_i[p] <= len_max) begin
        inc[p][slot_of(psc_pkg::IDX_RX_1024_MAX)] = LEN_W'(1); // see [RULE2]
      end
      if (tx_frame_done_i[p] && tx_good_i[p]) begin
        // Pause frames are good frames, so they land in the octet totals too
        if (tx_hi_prio_i[p]) begin
          inc[p][slot_of(psc_pkg::IDX_TX_HI_OCT)] = tx_frame_len_i[p]; // see [RULE1]
        end else begin
          inc[p][slot_of(psc_pkg::IDX_TX_LO_OCT)] = tx_frame_len_i[p]; // see [RULE1]
        end
        if (tx_pause_i[p]) begin
          inc[p][slot_of(psc_pkg::IDX_TX_PAUSE)] = LEN_W'(1);    // see [RULE4]
        end else if (tx_bcast_i[p]) begin
          inc[p][slot_of(psc_pkg::IDX_TX_BCAST)] = LEN_W'(1);    // see [RULE4]
        end else if (tx_mcast_i[p]) begin
          inc[p][slot_of(psc_pkg::IDX_TX_MCAST)] = LEN_W'(1);    // see [RULE4]
        end else begin
          inc[p][slot_of(psc_pkg::IDX_TX_UCAST)] = LEN_W'(1);    // see [RULE4]
        end
        if (tx_postponed_i[p]) begin
          inc[p][slot_of(psc_pkg::IDX_TX_POSTPONED)] = LEN_W'(1); // see [RULE5]
        end
        if (tx_coll_cnt_i[p] == COLL_W'(1)) begin
          inc[p][slot_of(psc_pkg::IDX_TX_ONE_COLL)] = LEN_W'(1);  // see [RULE8]
        end else if (tx_coll_cnt_i[p] > COLL_W'(1)) begin
          inc[p][slot_of(psc_pkg::IDX_TX_MULTI)] = LEN_W'(1);     // see [RULE8]
        end
      end
      if (tx_abandoned_i[p]) begin
        inc[p][slot_of(psc_pkg::IDX_TX_ABANDONED)] = LEN_W'(1);   // see [RULE7]
      end
      // The MAC flags a collision only once it is past the 512 bit-time window
      if (tx_late_coll_i[p]) begin
        inc[p][slot_of(psc_pkg::IDX_TX_LATE_COLL)] = LEN_W'(1);   // see [RULE3]
      end
      if (tx_coll_i[p] && half_duplex_i[p]) begin
        inc[p][slot_of(psc_pkg::IDX_TX_ALL_COLL)] = LEN_W'(1);    // see [RULE6]
      end
    end
  end

  // Per-port counters: a read clears, but an event in the same cycle still counts
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int p = 0; p < PORTS; p++) begin
        for (int k = 0; k < SLOTS; k++) begin
          cnt_r[p][k] <= '0;
          ovf_r[p][k] <= 1'b0;
        end
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        for (int k = 0; k < SLOTS; k++) begin
          logic             clr;
          logic [CNT_W:0]   sum;
          clr = trig && rd_slot_hit && (rd_port == 2'(p)) && (rd_slot == 4'(k));
          sum = add_wrap(clr ? '0 : cnt_r[p][k], inc[p][k]); // see [RULE15]
          cnt_r[p][k] <= sum[CNT_W-1:0];                      // see [RULE19]
          ovf_r[p][k] <= sum[CNT_W] | (ovf_r[p][k] & ~clr);   // see [RULE19]
        end
      end
    end
  end

  // Dropped-frame counters: free-running, wrap, never cleared by a read
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int d = 0; d < 2*PORTS; d++) begin
        drop_r[d] <= '0;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        drop_r[p]       <= drop_r[p] + DROP_W'(tx_drop_i[p]);         // see [RULE10]
        drop_r[PORTS+p] <= drop_r[PORTS+p] + DROP_W'(rx_drop_i[p]);   // see [RULE16]
      end
    end
  end

  // Table select and offset registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_r <= psc_pkg::REG_RESET_VAL;
      ofs_r <= psc_pkg::REG_RESET_VAL;
    end else if (reg_wr_i) begin
      if (reg_addr_i == psc_pkg::REG_TABLE_SELECT) begin
        sel_r <= reg_wdata_i;
      end
      if (reg_addr_i == psc_pkg::REG_TABLE_OFFSET) begin
        ofs_r <= reg_wdata_i;
      end
    end
  end

  // Result capture on the trigger; valid is set only by a read of a per-port offset and cleared by any other trigger
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_r <= '0;
    end else if (trig) begin
      result_r <= '0;
      if (rd_slot_hit && rd_port < 2'(PORTS)) begin
        result_r[psc_pkg::RES_OVF_BIT]   <= ovf_r[rd_port][rd_slot];   // see [RULE13]
        result_r[psc_pkg::RES_VALID_BIT] <= 1'b1;                      // see [RULE13]
        result_r[CNT_W-1:0]              <= cnt_r[rd_port][rd_slot];
      end else if (rd_drop_hit) begin
        result_r[DROP_W-1:0] <= drop_r[rd_drop];                       // see [RULE9] [RULE14]
      end else if (rd_mib && rd_port_area && rd_port < 2'(PORTS)) begin
        // Counters below the implemented range read as a valid zero
        result_r[psc_pkg::RES_VALID_BIT] <= 1'b1;
      end
    end
  end

  // Registered read data, one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_r <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        psc_pkg::REG_TABLE_SELECT: reg_rdata_r <= sel_r;
        psc_pkg::REG_TABLE_OFFSET: reg_rdata_r <= ofs_r;
        psc_pkg::REG_RESULT_3:     reg_rdata_r <= result_r[31:24];
        psc_pkg::REG_RESULT_2:     reg_rdata_r <= result_r[23:16];
        psc_pkg::REG_RESULT_1:     reg_rdata_r <= result_r[15:8];
        psc_pkg::REG_RESULT_0:     reg_rdata_r <= result_r[7:0];
        default:                   reg_rdata_r <= '0;
      endcase
    end
  end

  assign reg_rdata_o = reg_rdata_r;

endmodule

`default_nettype wire

// ===== test/psc_stats_monitor.sv
// Checker on the register port of the statistics counter bank
`timescale 1ns/1ps
`default_nettype none
module psc_stats_monitor (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o
);
  logic [7:0] sel_r;
  logic [7:0] off_r;
  logic       res;
  logic       low;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Shadow of select and offset; assumes the host writes select before each trigger
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_r <= 8'h00;
      off_r <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == 8'h79) begin
      sel_r <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == 8'h7A) begin
      off_r <= reg_wdata_i;
    end
  end
  // Result window read, and a per-port index below the implemented counters
  assign res = reg_rd_i && reg_addr_i[7:2] == 6'h20;
  assign low = sel_r == 8'h1C && off_r < 8'h60 && off_r[4:0] < 5'h13;
  hold_rdata_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (reg_rd_i && !res && reg_addr_i != 8'h79 && reg_addr_i != 8'h7A
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  sel_back_a: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == 8'h79
    |=> reg_rdata_o == $past(sel_r)) else $error("select readback wrong");
  off_back_a: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == 8'h7A
    |=> reg_rdata_o == $past(off_r)) else $error("offset readback wrong");
  low_valid_a: assert property (res && reg_addr_i == 8'h80 && low |=> reg_rdata_o == 8'h40)
    else $error("low index top byte wrong");
  low_zero_a: assert property (res && reg_addr_i != 8'h80 && low |=> reg_rdata_o == 8'h00)
    else $error("low index count not zero");
  drop_flags_a: assert property (res && sel_r == 8'h1D && !reg_addr_i[1] |=> reg_rdata_o == 8'h00)
    else $error("dropped result upper bytes not zero");
  other_table_a: assert property (res && sel_r[7:2] != 6'h07 |=> reg_rdata_o == 8'h00)
    else $error("other table result not zero");
  cover property (res && low);
  cover property (res && sel_r == 8'h1D);
  cover property (reg_rd_i && reg_addr_i == 8'h79);
endmodule
`default_nettype wire

// ===== test/psc_host_model.sv
// Host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module psc_host_model (
  input  wire logic       clk_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // One write; released lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  // One read; data is taken after the edge that accepted the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_rd_o = 1'b1;
    reg_addr_o = a;
    @(posedge clk_i);
    #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask
  // Indirect read; sweeps come far more often than any overflow could happen
  task automatic get(input logic [7:0] sel, input logic [7:0] off, output logic [31:0] w);
    wr(8'h79, sel);
    wr(8'h7A, off);
    for (int t = 0; t < 3; t++) begin
      rd(8'h80, w[31:24]);
      if (sel != 8'h1C || w[30] === 1'b1) break;
    end
    rd(8'h81, w[23:16]);
    rd(8'h82, w[15:8]);
    rd(8'h83, w[7:0]);
  endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the statistics counter bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic              clk_i = 1'b0;
  logic              reset_n_i = 1'b0;
  logic              reg_wr;
  logic              reg_rd;
  logic [7:0]        reg_addr;
  logic [7:0]        reg_wdata;
  logic [7:0]        reg_rdata;
  logic              max_long = 1'b0;
  logic [2:0]        hd = 3'b111;
  logic [2:0]        sig [13];
  logic [2:0][10:0]  len = '0;
  logic [2:0][4:0]   cc = '0;
  logic [31:0]       ex [12];
  logic [10:0]       lens [4] = '{11'h3FF, 11'h400, 11'h5F2, 11'h5F3};
  int                miscompares = 0;
  int                checks_done = 0;
  always #4 clk_i = ~clk_i;
  psc_host_model u_psc_host_model (.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));
  // Event strobes: done good hi pause bcast mcast postponed abandoned late coll txdrop rxdrop rxdone
  psc_stats_counters u_psc_stats_counters (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .max_frame_long_i(max_long), .half_duplex_i(hd), .rx_frame_done_i(sig[12]), .rx_frame_len_i(len),
    .tx_frame_done_i(sig[0]), .tx_frame_len_i(len), .tx_good_i(sig[1]), .tx_hi_prio_i(sig[2]),
    .tx_pause_i(sig[3]), .tx_bcast_i(sig[4]), .tx_mcast_i(sig[5]), .tx_postponed_i(sig[6]),
    .tx_coll_cnt_i(cc), .tx_abandoned_i(sig[7]), .tx_late_coll_i(sig[8]), .tx_coll_i(sig[9]),
    .tx_drop_i(sig[10]), .rx_drop_i(sig[11]));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // One-cycle pulse of the chosen strobes on one port
  task automatic ev(input int p, input logic [12:0] f, input logic [10:0] l, input logic [4:0] c);
    @(posedge clk_i);
    #1;
    for (int k = 0; k < 13; k++) sig[k][p] = f[k];
    len[p] = l;
    cc[p] = c;
    @(posedge clk_i);
    #1;
    for (int k = 0; k < 13; k++) sig[k] = 3'h0;
  endtask
  task automatic rc(input string n, input logic [7:0] s, input logic [7:0] o, input logic [31:0] e);
    logic [31:0] w;
    u_psc_host_model.get(s, o, w);
    chk(n, e, w);
  endtask
  task automatic rr(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] b;
    u_psc_host_model.rd(a, b);
    chk(n, {24'h0, e}, {24'h0, b});
  endtask
  initial begin
    for (int k = 0; k < 13; k++) sig[k] = 3'h0;
    repeat (8) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    rr("select reset", 8'h79, 8'h00);
    rc("other table", 8'h00, 8'h00, 32'h0);
    rc("port2 low index", 8'h1C, 8'h2E, 32'h4000_0000);
    rr("offset readback", 8'h7A, 8'h2E);
    rr("unmapped", 8'h55, 8'h00);
    $display("test registers done");
    for (int p = 0; p < 3; p++) begin
      ev(p, 13'h0353, 11'(p) + 11'h040, 5'h01);
      ev(p, 13'h0280, 11'h000, 5'h00);
      ev(p, 13'h002F, 11'h3E8, 5'h03);
      ev(p, 13'h0023, 11'h00A, 5'h00);
      ev(p, 13'h0003, 11'h014, 5'h00);
      ev(p, 13'h0011, 11'h032, 5'h00);
      ex = '{32'h4000_005E + 32'(p), 32'h4000_03E8, 32'h4000_0001, 32'h4000_0001, 32'h4000_0001,
        32'h4000_0001, 32'h4000_0001, 32'h4000_0001, 32'h4000_0002, 32'h4000_0001, 32'h4000_0001, 32'h4000_0001};
      for (int r = 0; r < 2; r++) begin
        for (int i = 0; i < 12; i++) begin
          rc("tx counter", 8'h1C, 8'(p) * 8'h20 + 8'h14 + 8'(i), r ? 32'h4000_0000 : ex[i]);
        end
      end
      foreach (lens[i]) ev(p, 13'h1000, lens[i], 5'h00);
      rc("rx bin std", 8'h1C, 8'(p) * 8'h20 + 8'h13, 32'h4000_0002);
      max_long = 1'b1;
      ev(p, 13'h1000, 11'h600, 5'h00);
      ev(p, 13'h1000, 11'h601, 5'h00);
      rc("rx bin long", 8'h1C, 8'(p) * 8'h20 + 8'h13, 32'h4000_0001);
      max_long = 1'b0;
      hd[p] = 1'b0;
      ev(p, 13'h0200, 11'h000, 5'h00);
      rc("full duplex coll", 8'h1C, 8'(p) * 8'h20 + 8'h1C, 32'h4000_0000);
      ev(p, 13'h0400, 11'h000, 5'h00);
      ev(p, 13'h0400, 11'h000, 5'h00);
      ev(p, 13'h0800, 11'h000, 5'h00);
      for (int r = 0; r < 2; r++) rc("tx drop", 8'h1D, 8'(p), 32'h2);
      rc("rx drop", 8'h1D, 8'(p) + 8'h03, 32'h1);
      $display("test port %0d done", p + 1);
    end
    complete_run();
  end
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule
bind psc_stats_counters psc_stats_monitor u_psc_stats_monitor (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o));
`default_nettype wire
